// ### logic/uerx_endpoint_rx_control.sv
// Endpoint receive control: token matching, handshakes, flush, warning events.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "uerx_params.svh"
module uerx_endpoint_rx_control #(
    parameter int FIFO_DEPTH = 64,
    parameter int PTR_W = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`UERX_ADDR_W-1:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    output logic irq,
    input wire logic [6:0] function_address_reg,
    input wire uerx_pkg::uerx_token_type token,
    input wire uerx_pkg::uerx_pkt_type pkt_end,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic fifo_rd,
    output logic [7:0] fifo_rdata,
    input wire logic tx_enabled,
    input wire logic tx_fifo_empty,
    output uerx_pkg::uerx_hs_type handshake,
    output logic handshake_valid,
    output logic [PTR_W:0] fifo_count_r
);
    import uerx_pkg::*;

    logic [15:0] rx_ctl_r;
    logic [15:0] ep_ctl_r;
    logic flush_pend_r;
    logic setup_held_r;
    logic [3:0] ev_stat_r;
    logic [3:0] ev_en_r;
    logic [7:0] mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0] wptr_r;
    logic [PTR_W-1:0] rptr_r;
    uerx_state_type state_r;
    uerx_hs_type hs_r;
    logic hs_valid_r;
    logic [7:0] rdata_r;

    logic rx_en;
    logic ign_setup;
    logic [1:0] warn_lim;
    logic [3:0] ep_num;
    logic ep_en;
    logic iso;
    logic stall;
    logic hit;
    logic busy;
    logic do_flush;
    logic fifo_full;
    logic [PTR_W:0] free_cnt;
    logic [7:0] free8;
    logic warn_now;
    logic [3:0] ev_set;
    logic wr_rxc;
    logic wr_epc;
    logic flush_wr;
    logic pkt_ok_out;

    assign rx_en = rx_ctl_r[`UERX_RXEN_BIT];
    assign ign_setup = rx_ctl_r[`UERX_IGN_BIT];
    assign warn_lim = rx_ctl_r[`UERX_WL_HI:`UERX_WL_LO];
    assign ep_num = ep_ctl_r[`UERX_EP_HI:`UERX_EP_LO];
    assign ep_en = ep_ctl_r[`UERX_EPEN_BIT];
    assign iso = ep_ctl_r[`UERX_ISO_BIT];
    assign stall = ep_ctl_r[`UERX_STALL_BIT];
    assign wr_rxc = bus_wr && bus_addr == `UERX_OFF_RXCTL;
    assign wr_epc = bus_wr && bus_addr == `UERX_OFF_EPCTL;
    assign flush_wr = wr_rxc && bus_wdata[`UERX_FLUSH_BIT];

    // Tokens only count when enabled and both address parts match.
    assign hit = token.valid && ep_en && token.addr == function_address_reg
        && token.ep == ep_num;

    assign busy = state_r == UERX_ST_RX_OUT || state_r == UERX_ST_RX_SETUP;
    // A flush must not tear a packet the MAC is still writing.
    assign do_flush = (flush_wr || flush_pend_r) && !busy;
    assign fifo_count_r = {1'b0, wptr_r - rptr_r} + {PTR_W'(0), fifo_full};
    assign free_cnt = (PTR_W+1)'(FIFO_DEPTH) - fifo_count_r;
    assign free8 = 8'(free_cnt);
    assign pkt_ok_out = pkt_end.valid && pkt_end.ok;

    logic full_r;
    assign fifo_full = full_r;

    always_comb begin
        case (warn_lim)
            `UERX_WL_5: warn_now = free8 < `UERX_LIM_5;
            `UERX_WL_17: warn_now = free8 < `UERX_LIM_17;
            default: warn_now = 1'b0;
        endcase
    end

    always_comb begin
        ev_set = 4'h0;
        ev_set[`UERX_EV_WARN] = warn_now;
        ev_set[`UERX_EV_PKT] = pkt_ok_out && state_r == UERX_ST_RX_OUT;
        ev_set[`UERX_EV_SETUP] = pkt_ok_out && state_r == UERX_ST_RX_SETUP;
        ev_set[`UERX_EV_FLUSH] = do_flush;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_ctl_r <= `UERX_RST_RXCTL;
        end else begin
            if (wr_rxc) begin
                // Flush is a write-only action, so it never sticks.
                rx_ctl_r <= bus_wdata & `UERX_RXCTL_MASK;
            end
            // Reception closes after each good OUT packet or OUT stall.
            if (pkt_ok_out && state_r == UERX_ST_RX_OUT) begin
                rx_ctl_r[`UERX_RXEN_BIT] <= 1'b0;
            end else if (hit && token.pid == UERX_PID_OUT && stall && rx_en)
            begin
                rx_ctl_r[`UERX_RXEN_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ep_ctl_r <= `UERX_RST_EPCTL;
        end else if (wr_epc) begin
            ep_ctl_r <= bus_wdata & `UERX_EPCTL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flush_pend_r <= 1'b0;
        end else if (do_flush) begin
            flush_pend_r <= 1'b0;
        end else if (flush_wr) begin
            flush_pend_r <= 1'b1;
        end
    end

    // Receive sequencing and handshake choice.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= UERX_ST_IDLE;
            hs_r <= UERX_HS_NONE;
            hs_valid_r <= 1'b0;
            setup_held_r <= 1'b0;
        end else begin
            hs_valid_r <= 1'b0;
            hs_r <= UERX_HS_NONE;
            if (do_flush) begin
                state_r <= UERX_ST_IDLE;
                setup_held_r <= 1'b0;
            end else if (hit && state_r == UERX_ST_IDLE) begin
                case (token.pid)
                    UERX_PID_SETUP: begin
                        // Stall plays no part here.
                        if (ign_setup) begin
                            state_r <= UERX_ST_IDLE;
                        end else if (setup_held_r) begin
                            state_r <= UERX_ST_DROP;
                        end else if (fifo_full) begin
                            state_r <= UERX_ST_IDLE;
                        end else begin
                            state_r <= UERX_ST_RX_SETUP;
                        end
                    end
                    UERX_PID_OUT: begin
                        setup_held_r <= 1'b0;
                        if (stall && rx_en) begin
                            hs_r <= UERX_HS_STALL;
                            hs_valid_r <= 1'b1;
                        end else if (rx_en && !fifo_full) begin
                            state_r <= UERX_ST_RX_OUT;
                        end else if (!iso) begin
                            hs_r <= UERX_HS_NAK;
                            hs_valid_r <= 1'b1;
                        end
                    end
                    UERX_PID_IN: begin
                        setup_held_r <= 1'b0;
                        hs_valid_r <= 1'b1;
                        if (stall && tx_enabled) begin
                            hs_r <= UERX_HS_STALL;
                        end else if (tx_enabled && !tx_fifo_empty) begin
                            hs_r <= UERX_HS_DATA;
                        end else if (!iso) begin
                            hs_r <= UERX_HS_NAK;
                        end else begin
                            hs_valid_r <= 1'b0;
                        end
                    end
                    default: begin
                        state_r <= UERX_ST_IDLE;
                    end
                endcase
            end else if (pkt_end.valid) begin
                case (state_r)
                    UERX_ST_RX_OUT: begin
                        hs_valid_r <= pkt_end.ok && !iso;
                        hs_r <= pkt_end.ok && !iso ? UERX_HS_ACK : UERX_HS_NONE;
                    end
                    UERX_ST_RX_SETUP: begin
                        hs_valid_r <= pkt_end.ok;
                        hs_r <= pkt_end.ok ? UERX_HS_ACK : UERX_HS_NONE;
                        setup_held_r <= pkt_end.ok;
                    end
                    UERX_ST_DROP: begin
                        hs_valid_r <= pkt_end.ok;
                        hs_r <= pkt_end.ok ? UERX_HS_ACK : UERX_HS_NONE;
                    end
                    default: begin
                        hs_valid_r <= 1'b0;
                    end
                endcase
                state_r <= UERX_ST_IDLE;
            end
        end
    end

    // FIFO storage; only packet payload of an accepted packet is stored.
    always_ff @(posedge clk) begin
        if (rx_byte_valid && busy && !fifo_full) begin
            mem_r[wptr_r] <= rx_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || do_flush) begin
            wptr_r <= '0;
            rptr_r <= '0;
            full_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            if (rx_byte_valid && busy && !fifo_full) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (fifo_rd && fifo_count_r != '0) begin
                rptr_r <= rptr_r + 1'b1;
                rdata_r <= mem_r[rptr_r];
            end
            if (rx_byte_valid && busy && !fifo_full &&
                !(fifo_rd && fifo_count_r != '0)) begin
                full_r <= PTR_W'(wptr_r + 1'b1) == rptr_r;
            end else if (fifo_rd && fifo_count_r != '0) begin
                full_r <= 1'b0;
            end
        end
    end

    // Sticky events; a new event beats a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            ev_stat_r <= 4'h0;
        end else begin
            ev_stat_r <= (ev_stat_r & ~((bus_wr &&
                bus_addr == `UERX_OFF_IRQ_CLR) ? bus_wdata[3:0] : 4'h0))
                | ev_set;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ev_en_r <= 4'h0;
        end else if (bus_wr && bus_addr == `UERX_OFF_IRQ_EN) begin
            ev_en_r <= bus_wdata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_rdata <= 16'h0000;
        end else if (bus_rd) begin
            case (bus_addr)
                `UERX_OFF_RXCTL: bus_rdata <= rx_ctl_r;
                `UERX_OFF_EPCTL: bus_rdata <= ep_ctl_r;
                `UERX_OFF_IRQ_STAT: bus_rdata <= {12'h000, ev_stat_r};
                `UERX_OFF_IRQ_EN: bus_rdata <= {12'h000, ev_en_r};
                `UERX_OFF_RXSTAT: bus_rdata <= {8'h00, flush_pend_r,
                    setup_held_r, state_r, 4'h0};
                default: bus_rdata <= 16'h0000;
            endcase
        end else begin
            bus_rdata <= 16'h0000;
        end
    end

    assign irq = |(ev_stat_r & ev_en_r);
    assign handshake = hs_r;
    assign handshake_valid = hs_valid_r;
    assign fifo_rdata = rdata_r;
endmodule

// ### logic/uerx_params.svh
// Offsets, field positions, reset values and limits of the endpoint receive control.
`ifndef UERX_PARAMS_SVH
`define UERX_PARAMS_SVH
`define UERX_ADDR_W 32
`define UERX_OFF_RXCTL 32'h5000185e
`define UERX_OFF_EPCTL 32'h50001860
`define UERX_OFF_IRQ_STAT 32'h50001a00
`define UERX_OFF_IRQ_CLR 32'h50001a04
`define UERX_OFF_IRQ_EN 32'h50001a08
`define UERX_OFF_RXSTAT 32'h50001a0c
`define UERX_RST_RXCTL 16'h0000
`define UERX_RST_EPCTL 16'h0000
`define UERX_RXEN_BIT 0
`define UERX_IGN_BIT 2
`define UERX_FLUSH_BIT 3
`define UERX_WL_LO 5
`define UERX_WL_HI 6
`define UERX_EP_LO 0
`define UERX_EP_HI 3
`define UERX_EPEN_BIT 4
`define UERX_ISO_BIT 5
`define UERX_STALL_BIT 7
`define UERX_WL_OFF 2'h0
`define UERX_WL_5 2'h1
`define UERX_WL_17 2'h2
`define UERX_LIM_5 8'h05
`define UERX_LIM_17 8'h11
`define UERX_EV_WARN 0
`define UERX_EV_PKT 1
`define UERX_EV_SETUP 2
`define UERX_EV_FLUSH 3
`define UERX_RXCTL_MASK 16'h0065
`define UERX_EPCTL_MASK 16'h00bf
`endif

// ### logic/uerx_pkg.sv
// Types shared by the endpoint receive control.
package uerx_pkg;
    typedef enum logic [1:0] {
        UERX_PID_OUT = 2'b00,
        UERX_PID_IN = 2'b01,
        UERX_PID_SETUP = 2'b10,
        UERX_PID_SOF = 2'b11
    } uerx_pid_type;
    typedef enum logic [2:0] {
        UERX_HS_NONE = 3'b000,
        UERX_HS_ACK = 3'b001,
        UERX_HS_NAK = 3'b010,
        UERX_HS_STALL = 3'b011,
        UERX_HS_DATA = 3'b100
    } uerx_hs_type;
    typedef struct packed {
        logic valid;
        uerx_pid_type pid;
        logic [6:0] addr;
        logic [3:0] ep;
    } uerx_token_type;
    typedef struct packed {
        logic valid;
        logic ok;
    } uerx_pkt_type;
    typedef enum logic [1:0] {
        UERX_ST_IDLE = 2'b00,
        UERX_ST_RX_OUT = 2'b01,
        UERX_ST_RX_SETUP = 2'b10,
        UERX_ST_DROP = 2'b11
    } uerx_state_type;
endpackage

// ### testbench/uerx_rx_asserts.sv
// Concurrent checks on the endpoint receive control ports.
`timescale 1ns/10ps
`include "uerx_params.svh"
module uerx_rx_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`UERX_ADDR_W-1:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [15:0] bus_rdata,
    input wire logic irq,
    input wire logic [6:0] function_address_reg,
    input wire uerx_pkg::uerx_token_type token,
    input wire logic tx_enabled,
    input wire uerx_pkg::uerx_hs_type handshake,
    input wire logic handshake_valid
);
    import uerx_pkg::*;
    logic [7:0] ep_r;
    logic hit;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Shadow of the endpoint control, so token checks know the set-up.
    always_ff @(posedge clk) begin
        if (rst) begin
            ep_r <= 8'h00;
        end else if (bus_wr && bus_addr == `UERX_OFF_EPCTL) begin
            ep_r <= bus_wdata[7:0];
        end
    end
    assign hit = token.valid && ep_r[4] && token.ep == ep_r[3:0]
        && token.addr == function_address_reg;
    property p_rd_idle;
        !$past(bus_rd) |-> bus_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");
    property p_ep_rd;
        $past(bus_rd && bus_addr == `UERX_OFF_EPCTL)
            |-> bus_rdata == {8'h00, ep_r & 8'hbf};
    endproperty
    a_ep_rd: assert property (p_ep_rd) else $error("epctl");
    property p_hs_one;
        handshake_valid |=> !handshake_valid;
    endproperty
    a_hs_one: assert property (p_hs_one) else $error("hs width");
    property p_no_setup_stall;
        token.valid && token.pid == UERX_PID_SETUP
            |=> !(handshake_valid && handshake == UERX_HS_STALL);
    endproperty
    a_no_setup_stall: assert property (p_no_setup_stall) else $error("st");
    property p_iso;
        token.valid && ep_r[5]
            |=> !(handshake_valid && handshake == UERX_HS_NAK);
    endproperty
    a_iso: assert property (p_iso) else $error("iso nak");
    property p_off;
        token.valid && !ep_r[4] |=> !handshake_valid;
    endproperty
    a_off: assert property (p_off) else $error("disabled");
    property p_miss;
        token.valid && ep_r[4] && !hit |=> !handshake_valid;
    endproperty
    a_miss: assert property (p_miss) else $error("mismatch");
    property p_stall_in;
        hit && ep_r[7] && token.pid == UERX_PID_IN && tx_enabled
            |=> handshake_valid && handshake == UERX_HS_STALL;
    endproperty
    a_stall_in: assert property (p_stall_in) else $error("stall");
    property p_irq_off;
        bus_wr && bus_addr == `UERX_OFF_IRQ_EN && bus_wdata[3:0] == 4'h0
            |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq");
    c_ack: cover property (handshake_valid && handshake == UERX_HS_ACK);
    c_stall: cover property (handshake_valid && handshake == UERX_HS_STALL);
    c_irq: cover property (irq);
endmodule
bind uerx_endpoint_rx_control uerx_rx_asserts chk (.*);

// ### testbench/uerx_host_model.sv
// Host side model: issues tokens and data packets to the endpoint.
`timescale 1ns/10ps
module uerx_host_model (
    input wire logic clk,
    output uerx_pkg::uerx_token_type token,
    output uerx_pkg::uerx_pkt_type pkt_end,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte
);
    import uerx_pkg::*;
    initial begin
        token = '0;
        pkt_end = '0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // Idle fields are flipped so the endpoint cannot lean on stale bits.
    task automatic tok(input uerx_pid_type p, input logic [3:0] e);
        @(posedge clk);
        token <= '{1'b1, p, 7'h2a, e};
        @(posedge clk);
        token <= {1'b0, ~token[12:0]};
    endtask
    task automatic pkt(input int n, input logic ok);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_byte_valid <= 1'b1;
            rx_byte <= i[7:0];
        end
        @(posedge clk);
        rx_byte_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        pkt_end <= '{1'b1, ok};
        @(posedge clk);
        pkt_end <= '{1'b0, ~ok};
    endtask
endmodule

// ### testbench/uerx_endpoint_rx_control_tb.sv
// Self-checking bench for the endpoint receive control.
`timescale 1ns/10ps
`include "uerx_params.svh"
module uerx_endpoint_rx_control_tb;
    import uerx_pkg::*;
    localparam logic [3:0] ack = {1'b1, UERX_HS_ACK};
    localparam logic [3:0] nak = {1'b1, UERX_HS_NAK};
    localparam logic [3:0] stl = {1'b1, UERX_HS_STALL};
    localparam logic [3:0] dat = {1'b1, UERX_HS_DATA};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [`UERX_ADDR_W-1:0] bus_addr = '0;
    logic [15:0] bus_wdata = 16'h0000;
    logic [15:0] bus_rdata, v;
    logic bus_wr = 1'b0, bus_rd = 1'b0, fifo_rd = 1'b0, irq;
    logic tx_enabled = 1'b0, tx_fifo_empty = 1'b0, handshake_valid;
    logic [6:0] function_address_reg = 7'h2a;
    logic [7:0] fifo_rdata, rx_byte;
    logic [5:0] fifo_count_r;
    logic rx_byte_valid;
    uerx_token_type token;
    uerx_pkt_type pkt_end;
    uerx_hs_type handshake;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    // A shallow FIFO brings the warning limits within a short packet.
    uerx_endpoint_rx_control #(.FIFO_DEPTH(32), .PTR_W(5)) uut (.*);
    uerx_host_model host (.*);
    always #12.5 clk = ~clk;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
        // Let the write settle before any caller looks at the outputs.
        #1;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 v = bus_rdata;
    endtask
    task automatic tk(input uerx_pid_type p, input logic [3:0] e,
        input logic [3:0] x);
        host.tok(p, e);
        #1 chk({handshake_valid, handshake}, x);
    endtask
    task automatic pk(input int n, input logic [3:0] x);
        host.pkt(n, 1'b1);
        #1 chk({handshake_valid, handshake}, x);
    endtask
    task automatic pop(input logic [7:0] x);
        @(posedge clk);
        fifo_rd <= 1'b1;
        @(posedge clk);
        fifo_rd <= 1'b0;
        #1 chk(fifo_rdata, x);
    endtask
    task automatic t_stall;
        rd(`UERX_OFF_EPCTL);
        chk(v, 16'h0000);
        rd(32'h50001a10);
        chk(v, 16'h0000);
        tk(UERX_PID_IN, 4'h0, 4'h0);
        tx_enabled <= 1'b1;
        wr(`UERX_OFF_EPCTL, 16'h0093);
        tk(UERX_PID_IN, 4'h3, stl);
        tk(UERX_PID_IN, 4'h4, 4'h0);
        wr(`UERX_OFF_RXCTL, 16'h0001);
        tk(UERX_PID_OUT, 4'h3, stl);
        rd(`UERX_OFF_RXCTL);
        chk(v, 16'h0000);
        tk(UERX_PID_SETUP, 4'h3, 4'h0);
        pk(8, ack);
    endtask
    task automatic t_setup;
        wr(`UERX_OFF_EPCTL, 16'h0013);
        tk(UERX_PID_SETUP, 4'h3, 4'h0);
        pk(8, ack);
        chk(fifo_count_r, 6'h08);
        rd(`UERX_OFF_RXSTAT);
        chk(v, 16'h0040);
        tk(UERX_PID_IN, 4'h3, dat);
        tk(UERX_PID_SETUP, 4'h3, 4'h0);
        host.pkt(2, 1'b0);
        #1 chk({handshake_valid, handshake}, 4'h0);
        wr(`UERX_OFF_RXCTL, 16'h0004);
        tk(UERX_PID_SETUP, 4'h3, 4'h0);
        pk(8, 4'h0);
    endtask
    task automatic t_out;
        wr(`UERX_OFF_RXCTL, 16'h0008);
        rd(`UERX_OFF_IRQ_STAT);
        chk(v & 16'h000c, 16'h000c);
        wr(`UERX_OFF_IRQ_CLR, 16'h000f);
        chk(fifo_count_r, 6'h00);
        wr(`UERX_OFF_RXCTL, 16'h0001);
        tk(UERX_PID_OUT, 4'h3, 4'h0);
        pk(4, ack);
        tk(UERX_PID_OUT, 4'h3, nak);
        rd(`UERX_OFF_IRQ_STAT);
        chk(v & 16'h0002, 16'h0002);
        wr(`UERX_OFF_IRQ_EN, 16'h0002);
        chk(irq, 1'b1);
        wr(`UERX_OFF_IRQ_EN, 16'h0000);
        chk(irq, 1'b0);
        wr(`UERX_OFF_IRQ_CLR, 16'h0002);
        wr(`UERX_OFF_IRQ_EN, 16'h0002);
        chk(irq, 1'b0);
        wr(`UERX_OFF_RXCTL, 16'h0001);
        tk(UERX_PID_OUT, 4'h3, 4'h0);
        fork
            pk(6, ack);
            wr(`UERX_OFF_RXCTL, 16'h0009);
        join
        wr(`UERX_OFF_IRQ_CLR, 16'h000f);
        chk(fifo_count_r, 6'h00);
    endtask
    task automatic warn(input logic [15:0] c, input logic x);
        wr(`UERX_OFF_RXCTL, c);
        wr(`UERX_OFF_IRQ_CLR, 16'h000f);
        rd(`UERX_OFF_IRQ_STAT);
        chk(v[0], x);
    endtask
    task automatic t_warn;
        wr(`UERX_OFF_RXCTL, 16'h0001);
        tk(UERX_PID_OUT, 4'h3, 4'h0);
        pk(16, ack);
        warn(16'h0020, 1'b0);
        warn(16'h0040, 1'b1);
        warn(16'h0060, 1'b0);
        warn(16'h0000, 1'b0);
        wr(`UERX_OFF_EPCTL, 16'h0033);
        tx_fifo_empty <= 1'b1;
        host.tok(UERX_PID_IN, 4'h3);
        #1 chk(handshake_valid && handshake == UERX_HS_NAK, 1'b0);
        host.tok(UERX_PID_OUT, 4'h3);
        #1 chk(handshake_valid && handshake == UERX_HS_NAK, 1'b0);
        pop(8'h00);
        pop(8'h01);
        chk(fifo_count_r, 6'h0e);
    endtask
    task automatic test_done;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_stall();
        t_setup();
        t_out();
        t_warn();
        test_done();
    end
endmodule
